// [design/mcreg_pkg.sv]
// Package with the register map, field layout and link framing constants of the modem codec bank
package mcreg_pkg;

    // ==========================================================================
    // Register offsets (7-bit codec register index)
    // ==========================================================================
    localparam logic [6:0] OFS_MODEM_IDENTIFICATION      = 7'h3C;
    localparam logic [6:0] OFS_MODEM_POWER_AND_READINESS = 7'h3E;
    localparam logic [6:0] OFS_LINE1_SAMPLE_RATE         = 7'h40;
    localparam logic [6:0] OFS_LINE2_SAMPLE_RATE         = 7'h42;
    localparam logic [6:0] OFS_LINE1_GAIN_AND_MUTE       = 7'h46;
    localparam logic [6:0] OFS_LINE2_GAIN_AND_MUTE       = 7'h48;
    localparam logic [6:0] OFS_VIRTUAL_PIN_DIRECTION     = 7'h4C;
    localparam logic [6:0] OFS_VIRTUAL_PIN_POLARITY      = 7'h4E;
    localparam logic [6:0] OFS_VIRTUAL_PIN_LATCHING      = 7'h50;
    localparam logic [6:0] OFS_VIRTUAL_PIN_WAKE_MASK     = 7'h52;
    localparam logic [6:0] OFS_VIRTUAL_PIN_STATE         = 7'h54;
    localparam logic [6:0] OFS_LINK_POWER_AND_MISC       = 7'h56;
    localparam logic [6:0] OFS_CHIP_REVISION             = 7'h5A;
    localparam logic [6:0] OFS_LINE_SIDE_CONFIG_ONE      = 7'h5C;
    localparam logic [6:0] OFS_LINE_SIDE_STATE           = 7'h5E;
    localparam logic [6:0] OFS_LINE_SIDE_CONFIG_TWO      = 7'h62;
    localparam logic [6:0] OFS_LINE_SIDE_CONFIG_THREE    = 7'h64;
    localparam logic [6:0] OFS_MAKER_CODE_LOW            = 7'h7C;
    localparam logic [6:0] OFS_MAKER_CODE_HIGH           = 7'h7E;

    // ==========================================================================
    // Field positions and values
    // ==========================================================================
    localparam int unsigned POS_ROLE_LSB      = 14;
    localparam int unsigned POS_PD_LSB        = 8;
    localparam logic [1:0]  ROLE_PRIMARY      = 2'h0;
    localparam logic [1:0]  ROLE_FIRST_LINE   = 2'h1;
    localparam logic [1:0]  ROLE_SECOND_LINE  = 2'h2;
    localparam logic [1:0]  ROLE_FACTORY_TEST = 2'h3;
    localparam logic [3:0]  SLOT_FIRST_LINE   = 4'h5;
    localparam logic [3:0]  SLOT_SECOND_LINE  = 4'hA;
    localparam logic [1:0]  STAT_TOP_BITS     = 2'h3;
    localparam logic [5:0]  RST_PD            = 6'h3F;
    localparam logic [15:0] RST_STATUS_WORD   = 16'hFF00;

    // ==========================================================================
    // Frame layout: slot 0 is 16 bits, slots 1 and 2 are 20 bits each
    // ==========================================================================
    localparam int unsigned HEAD_BITS   = 56;
    localparam logic [5:0]  HEAD_LAST   = 6'h37;
    localparam int unsigned TAG_FRAME   = 15;
    localparam int unsigned TAG_ADDR    = 14;
    localparam int unsigned TAG_DATA    = 13;
    localparam logic [1:0]  STRAP_WAIT  = 2'h2;

    // Power-down controls, most significant first as in the status word
    typedef struct packed {
        logic pd_line2_transmit;
        logic pd_line2_receive;
        logic pd_line1_transmit;
        logic pd_line1_receive;
        logic pd_reserved_future;
        logic pd_pin_expander;
    } mcreg_pd_t;

    // One decoded register access from the link
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [6:0]  addr;
        logic [15:0] data;
    } mcreg_cmd_t;

    // Link frame tracking states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_FRAME = 2'b10
    } mcreg_state_t;

endpackage

// [design/mcreg_top.sv]
// Modem codec identification and power/readiness register bank behind the serial codec link
`timescale 1ns/1ps
module mcreg_top (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              bit_clk_i,
    input  wire logic              sync_i,
    input  wire logic              sdata_out_i,
    input  wire logic              role_select_high_n_i,
    input  wire logic              role_select_low_n_i,
    input  wire logic              vref_nominal_i,
    output logic                   sdata_in_o,
    output mcreg_pkg::mcreg_pd_t   pd_ctrl_o,
    output logic                   line_side_pd_o,
    output logic [3:0]             line_data_slot_o
);
    import mcreg_pkg::*;

    // ==========================================================================
    // Input synchronisers
    // ==========================================================================
    logic [2:0]   bclk_s;
    logic [1:0]   sync_s;
    logic [1:0]   sdo_s;
    logic [1:0]   strap_s1;
    logic [1:0]   strap_s2;
    logic [1:0]   vref_s;

    // Pins come from another domain; the third bit clock stage only feeds edge detect
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_s   <= 3'h0;
            sync_s   <= 2'h0;
            sdo_s    <= 2'h0;
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            vref_s   <= 2'h0;
        end else begin
            bclk_s   <= {bclk_s[1:0], bit_clk_i};
            sync_s   <= {sync_s[0], sync_i};
            sdo_s    <= {sdo_s[0], sdata_out_i};
            strap_s1 <= {role_select_high_n_i, role_select_low_n_i};
            strap_s2 <= strap_s1;
            vref_s   <= {vref_s[0], vref_nominal_i};
        end
    end

    logic bclk_rise;
    logic bclk_fall;
    assign bclk_rise = bclk_s[1] & ~bclk_s[2];
    assign bclk_fall = ~bclk_s[1] & bclk_s[2];

    // ==========================================================================
    // Strap capture
    // ==========================================================================
    logic [1:0]   role_r;
    logic [1:0]   strap_cnt_r;
    logic         role_taken_r;

    // Straps are caught after release, once the synchroniser holds a settled value
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            role_r       <= ROLE_PRIMARY;
            strap_cnt_r  <= 2'h0;
            role_taken_r <= 1'b0;
        end else if (!role_taken_r) begin
            if (strap_cnt_r == STRAP_WAIT) begin
                role_r       <= ~strap_s2;
                role_taken_r <= 1'b1;
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    // Role decode: only 01 and 10 answer as secondary
    logic role_secondary;
    assign role_secondary = (role_r == ROLE_FIRST_LINE) || (role_r == ROLE_SECOND_LINE);

    // ==========================================================================
    // Register words
    // ==========================================================================
    mcreg_pd_t    pd_r;
    logic [5:0]   ready_r;
    logic [15:0]  id_word;
    logic [15:0]  stat_word;

    assign id_word = {role_r, 12'h000,
                      role_r == ROLE_SECOND_LINE,
                      role_r == ROLE_FIRST_LINE};
    assign stat_word = {STAT_TOP_BITS, pd_r, 2'h0, ready_r};

    // Read mux; everything outside the two words answers zero
    function automatic logic [15:0] read_word(input logic [6:0] addr);
        logic [15:0] w;
        w = 16'h0000;
        case (addr)
            OFS_MODEM_IDENTIFICATION:      w = id_word;
            OFS_MODEM_POWER_AND_READINESS: w = stat_word;
            default:                       w = 16'h0000;
        endcase
        return w;
    endfunction

    // ==========================================================================
    // Link frame receiver
    // ==========================================================================
    mcreg_state_t state_r;
    logic         sync_prev_r;
    logic [5:0]   rx_cnt_r;
    logic [55:0]  rx_sr_r;
    logic         frame_start;
    logic [55:0]  rx_full;

    assign frame_start = bclk_rise & sync_s[1] & ~sync_prev_r;
    assign rx_full     = {rx_sr_r[54:0], sdo_s[1]};

    // Frame begins on a rising sync seen at a bit clock rising edge
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            sync_prev_r <= 1'b0;
            rx_cnt_r    <= 6'h00;
            rx_sr_r     <= 56'h0;
        end else begin
            if (bclk_rise) begin
                sync_prev_r <= sync_s[1];
            end
            case (state_r)
                ST_IDLE: begin
                    if (frame_start) begin
                        state_r  <= ST_FRAME;
                        rx_cnt_r <= 6'h00;
                    end
                end
                ST_FRAME: begin
                    // Data is sampled on falling bit clock edges
                    if (bclk_fall) begin
                        rx_sr_r  <= rx_full;
                        rx_cnt_r <= rx_cnt_r + 6'h01;
                        if (rx_cnt_r == HEAD_LAST) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================================
    // Command decode
    // ==========================================================================
    mcreg_cmd_t   cmd_r;
    logic [15:0]  tag;
    logic         addr_ok;

    assign tag = rx_full[55:40];
    // Secondary ignores tag bits 14/13 and relies on the codec id instead
    assign addr_ok = tag[TAG_FRAME] &&
                     (role_secondary ? (tag[1:0] == role_r)
                                     : (tag[TAG_ADDR] && tag[1:0] == ROLE_PRIMARY));

    // One-cycle command pulse when slots 0 to 2 have arrived
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_r <= '0;
        end else begin
            cmd_r.valid <= (state_r == ST_FRAME) && bclk_fall &&
                           (rx_cnt_r == HEAD_LAST) && addr_ok;
            cmd_r.write <= ~rx_full[39] & (role_secondary | tag[TAG_DATA]);
            cmd_r.addr  <= rx_full[38:32];
            cmd_r.data  <= rx_full[19:4];
        end
    end

    // ==========================================================================
    // Power-down controls and readiness
    // ==========================================================================
    // Only cold reset and a power/readiness register write touch these; link sleep leaves them as they are
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_r <= RST_PD;
        end else if (cmd_r.valid && cmd_r.write &&
                     cmd_r.addr == OFS_MODEM_POWER_AND_READINESS) begin
            pd_r <= cmd_r.data[POS_PD_LSB +: 6];
        end
    end

    // Converter ready needs its power-down clear and the reference up
    genvar gi;
    generate
        for (gi = 2; gi < 6; gi++) begin : g_conv_ready
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    ready_r[gi] <= 1'b0;
                end else begin
                    ready_r[gi] <= ~pd_r[gi] & vref_s[1];
                end
            end
        end
    endgenerate

    // Reference and pin logic readiness; reserved pd bit 1 feeds no ready flag
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_r[1:0] <= 2'h0;
        end else begin
            ready_r[1] <= vref_s[1];
            ready_r[0] <= ~pd_r.pd_pin_expander;
        end
    end

    // Converter enables follow the register one cycle later
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_ctrl_o      <= RST_PD;
            line_side_pd_o <= 1'b1;
            line_data_slot_o <= 4'h0;
        end else begin
            pd_ctrl_o      <= pd_r;
            line_side_pd_o <= &pd_r;
            case (role_r)
                ROLE_FIRST_LINE:  line_data_slot_o <= SLOT_FIRST_LINE;
                ROLE_SECOND_LINE: line_data_slot_o <= SLOT_SECOND_LINE;
                default:          line_data_slot_o <= 4'h0;
            endcase
        end
    end

    // ==========================================================================
    // Read response and transmitter
    // ==========================================================================
    logic         resp_pend_r;
    logic [6:0]   resp_addr_r;
    logic [15:0]  resp_data_r;
    logic [55:0]  tx_sr_r;
    logic [55:0]  tx_load;

    // Status frame: ready, valid address, valid data, then slots 1 and 2
    assign tx_load = {1'b1, resp_pend_r, resp_pend_r, 13'h0000,
                      1'b0, resp_addr_r, 12'h000,
                      resp_data_r, 4'h0};

    // A read is answered in the next frame; a new read overrides an unsent one
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            resp_pend_r <= 1'b0;
            resp_addr_r <= 7'h00;
            resp_data_r <= 16'h0000;
        end else if (cmd_r.valid && !cmd_r.write) begin
            resp_pend_r <= 1'b1;
            resp_addr_r <= cmd_r.addr;
            resp_data_r <= read_word(cmd_r.addr);
        end else if (frame_start) begin
            resp_pend_r <= 1'b0;
        end
    end

    // Shift out on rising bit clock edges, MSB first
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sr_r    <= 56'h0;
            sdata_in_o <= 1'b0;
        end else if (frame_start) begin
            sdata_in_o <= tx_load[55];
            tx_sr_r    <= {tx_load[54:0], 1'b0};
        end else if (bclk_rise) begin
            sdata_in_o <= tx_sr_r[55];
            tx_sr_r    <= {tx_sr_r[54:0], 1'b0};
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================
    property p_unmapped_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cmd_r.valid && !cmd_r.write && cmd_r.addr != OFS_MODEM_IDENTIFICATION &&
         cmd_r.addr != OFS_MODEM_POWER_AND_READINESS) |=> (resp_data_r == 16'h0000);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read did not return zero");

    property p_strap_role;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(role_taken_r) |-> (role_r == ~$past(strap_s2));
    endproperty
    a_strap_role: assert property (p_strap_role)
        else $error("role field does not match straps");

    property p_second_line;
        @(posedge ref_clk_i) disable iff (rst_i)
        (role_r == 2'h2 && $past(role_r) == 2'h2) |-> (id_word[1:0] == 2'h2 &&
                                                        line_data_slot_o == 4'hA);
    endproperty
    a_second_line: assert property (p_second_line)
        else $error("second line flag or slot wrong");

    property p_first_line;
        @(posedge ref_clk_i) disable iff (rst_i)
        (role_r == 2'h1 && $past(role_r) == 2'h1) |-> (id_word[1:0] == 2'h1 &&
                                                        line_data_slot_o == 4'h5);
    endproperty
    a_first_line: assert property (p_first_line)
        else $error("first line flag or slot wrong");

    property p_reset_word;
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (stat_word == RST_STATUS_WORD);
    endproperty
    a_reset_word: assert property (p_reset_word)
        else $error("status word not 0xFF00 after reset");

    property p_pd_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cmd_r.valid && cmd_r.write && cmd_r.addr == OFS_MODEM_POWER_AND_READINESS) |=>
            (stat_word[13:8] == $past(cmd_r.data[13:8]) && stat_word[15:14] == 2'h3);
    endproperty
    a_pd_write: assert property (p_pd_write)
        else $error("power-down write not taken");

    property p_line_side_off;
        @(posedge ref_clk_i) disable iff (rst_i)
        (&pd_r) |=> line_side_pd_o;
    endproperty
    a_line_side_off: assert property (p_line_side_off)
        else $error("line side not powered down");

    // Any cleared control must wake the line side again
    property p_line_side_on;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(&pd_r) |=> !line_side_pd_o;
    endproperty
    a_line_side_on: assert property (p_line_side_on)
        else $error("line side held down with a control cleared");

    property p_ready_low_in_pd;
        @(posedge ref_clk_i) disable iff (rst_i)
        (pd_r[5:2] != 4'h0) |=> ((stat_word[5:2] & $past(pd_r[5:2])) == 4'h0);
    endproperty
    a_ready_low_in_pd: assert property (p_ready_low_in_pd)
        else $error("ready flag high while powered down");

    property p_reserved_bits;
        @(posedge ref_clk_i) disable iff (rst_i)
        cmd_r.valid |-> (id_word[13:2] == 12'h000 && stat_word[7:6] == 2'h0);
    endproperty
    a_reserved_bits: assert property (p_reserved_bits)
        else $error("reserved bits not zero");

    property p_read_reply;
        @(posedge ref_clk_i) disable iff (rst_i)
        (frame_start && resp_pend_r) |=> (sdata_in_o && tx_sr_r[55:54] == 2'h3);
    endproperty
    a_read_reply: assert property (p_read_reply)
        else $error("read reply tags missing");

endmodule

// [tb/mcreg_host_model.sv]
// Host controller model: drives serial link frames and captures the codec reply
`timescale 1ns/1ps
module mcreg_host_model (
    output logic      bit_clk_o,
    output logic      sync_o,
    output logic      sdata_out_o,
    input  wire logic sdata_in_i
);
    // ==========================================================================
    // Frame engine
    // ==========================================================================
    // Idle levels before the first frame
    initial begin
        bit_clk_o   = 1'b0;
        sync_o      = 1'b0;
        sdata_out_o = 1'b0;
    end

    // Clock stands still between frames; released data toggles so no stale bit is seen
    task automatic frame(input logic [15:0] tag, input logic [19:0] s1,
                         input logic [19:0] s2, output logic [55:0] rx);
        logic [55:0] tx;
        tx          = {tag, s1, s2};
        sync_o      = 1'b1;
        sdata_out_o = tx[55];
        #100;
        for (int i = 0; i < 64; i++) begin
            if (i > 0) begin
                sdata_out_o = (i < 56) ? tx[55 - i] : ~sdata_out_o;
            end
            if (i == 16) begin
                sync_o = 1'b0;
            end
            bit_clk_o = 1'b1;
            #100;
            bit_clk_o = 1'b0;
            #100;
            // Sampled late in the low half: reply bit moves only after the synced rise
            if (i < 56) begin
                rx[55 - i] = sdata_in_i;
            end
        end
        repeat (4) begin
            #100;
            sdata_out_o = ~sdata_out_o;
        end
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the modem codec register bank over the serial link
`timescale 1ns/1ps
module tb;
    import mcreg_pkg::*;
    logic        ref_clk;
    logic        rst;
    logic        bclk;
    logic        sync;
    logic        sdo;
    logic        sdi;
    logic        rs_hi_n;
    logic        rs_lo_n;
    logic        vref;
    logic        lsp;
    mcreg_pd_t   pd;
    logic [3:0]  slot;
    logic [1:0]  role;
    logic [31:0] seed;
    int          fail_count;
    int          n_compared;

    // ==========================================================================
    // Design, host model and clock
    // ==========================================================================
    mcreg_top mcreg_top_inst (.ref_clk_i(ref_clk), .rst_i(rst), .bit_clk_i(bclk),
        .sync_i(sync), .sdata_out_i(sdo), .role_select_high_n_i(rs_hi_n),
        .role_select_low_n_i(rs_lo_n), .vref_nominal_i(vref), .sdata_in_o(sdi),
        .pd_ctrl_o(pd), .line_side_pd_o(lsp), .line_data_slot_o(slot));
    mcreg_host_model mcreg_host_model_inst (.bit_clk_o(bclk), .sync_o(sync),
        .sdata_out_o(sdo), .sdata_in_i(sdi));

    // Free running 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    // ==========================================================================
    // Expectations and helpers
    // ==========================================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Readiness follows power-down and reference; pin logic ignores the reference
    function automatic logic [15:0] st_exp(input logic [5:0] p, input logic v);
        return {STAT_TOP_BITS, p, 2'h0, ~p[5:2] & {4{v}}, v, ~p[0]};
    endfunction

    function automatic logic [15:0] id_exp(input logic [1:0] r);
        return {r, 12'h000, r == ROLE_SECOND_LINE, r == ROLE_FIRST_LINE};
    endfunction

    // Primary and test roles use tag bits; secondary roles use the codec id
    function automatic logic [15:0] hdr(input logic w);
        if (role == ROLE_FIRST_LINE || role == ROLE_SECOND_LINE) begin
            return {14'h2000, role};
        end
        return w ? 16'hE000 : 16'hC000;
    endfunction

    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [55:0] rx;
        mcreg_host_model_inst.frame(hdr(1'b1), {1'b0, a, 12'h000}, {d, 4'h0}, rx);
    endtask

    // Reply arrives in the next frame, which carries no valid command
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        logic [55:0] rx;
        mcreg_host_model_inst.frame(hdr(1'b0), {1'b1, a, 12'h000}, 20'h00000, rx);
        mcreg_host_model_inst.frame(16'h0000, 20'h00000, 20'h00000, rx);
        chk16("echo", {3'h7, 6'h00, a}, {rx[55:53], 6'h00, rx[38:32]});
        d = rx[19:4];
    endtask

    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================================
    // Scenarios: each role, reset defaults, power-down writes, refused accesses
    // ==========================================================================
    initial begin
        logic [15:0] d;
        logic [15:0] w;
        logic [55:0] rx;
        ref_clk    = 1'b0;
        rst        = 1'b1;
        rs_hi_n    = 1'b1;
        rs_lo_n    = 1'b1;
        vref       = 1'b0;
        role       = 2'h0;
        seed       = 32'd62648;
        fail_count = 0;
        n_compared = 0;
        for (int r = 0; r < 4; r++) begin
            @(negedge ref_clk);
            role               = r[1:0];
            rst                = 1'b1;
            {rs_hi_n, rs_lo_n} = ~role;
            vref               = r[0];
            repeat (20) @(negedge ref_clk);
            chk16("reset_outputs", {5'h00, RST_PD, 1'b1, 4'h0}, {5'h00, pd, lsp, slot});
            rst = 1'b0;
            repeat (8) @(negedge ref_clk);
            chk16("line_slot", {12'h000, (role == ROLE_FIRST_LINE) ? SLOT_FIRST_LINE :
                  (role == ROLE_SECOND_LINE) ? SLOT_SECOND_LINE : 4'h0}, {12'h000, slot});
            rd(OFS_MODEM_IDENTIFICATION, d);
            chk16("ident", id_exp(role), d);
            rd(OFS_MODEM_POWER_AND_READINESS, d);
            chk16("status_reset", st_exp(RST_PD, vref), d);
            wr(OFS_LINE1_SAMPLE_RATE, 16'h1F40);
            for (int k = 0; k < 4; k++) begin
                seed = xs(seed);
                w    = (k == 0) ? 16'h3F00 : (k == 1) ? 16'h0000 : seed[15:0];
                @(negedge ref_clk);
                vref = seed[16];
                wr(OFS_MODEM_POWER_AND_READINESS, w);
                chk16("pd_out", {9'h000, w[13:8], &w[13:8]}, {9'h000, pd, lsp});
                rd(OFS_MODEM_POWER_AND_READINESS, d);
                chk16("status", st_exp(w[13:8], vref), d);
            end
            wr(OFS_MODEM_IDENTIFICATION, seed[31:16]);
            rd(OFS_MODEM_IDENTIFICATION, d);
            chk16("ident_ro", id_exp(role), d);
            // Write carrying a codec id that is not ours must be dropped
            mcreg_host_model_inst.frame({14'h3800, (role == ROLE_FIRST_LINE) ? 2'h2 : 2'h1},
                {1'b0, OFS_MODEM_POWER_AND_READINESS, 12'h000}, {~w, 4'h0}, rx);
            rd(OFS_MODEM_POWER_AND_READINESS, d);
            chk16("refused_write", st_exp(w[13:8], vref), d);
            rd({3'h0, seed[20:17]}, d);
            chk16("unmapped", 16'h0000, d);
        end
        final_report();
    end

    // Watchdog well beyond the expected run of about 1.3 ms, under 100k clocks
    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule
